// ===== core/diag_adc_pkg.sv
// Package: register map, field layout and selection codes of the conversion request queue
package diag_adc_pkg;
	localparam int unsigned NUM_SLOTS     = 4;
	localparam int unsigned QUEUE_DEPTH   = 4;
	localparam int unsigned SEL_W         = 7;
	localparam int unsigned RES_W         = 10;
	localparam int unsigned FRAME_W       = 20;
	localparam int unsigned ADDR_W        = 7;

	// Register offsets (command addresses)
	localparam logic [6:0] MEASURE_SLOT_A_OFS = 7'h3a;
	localparam logic [6:0] MEASURE_SLOT_B_OFS = 7'h3b;
	localparam logic [6:0] MEASURE_SLOT_C_OFS = 7'h3c;
	localparam logic [6:0] MEASURE_SLOT_D_OFS = 7'h3d;

	// Read frame field positions
	localparam int unsigned FRESH_BIT   = 19;
	localparam int unsigned SEL_ECHO_LO = 12;
	localparam int unsigned RESULT_LO   = 0;

	// Reset values
	localparam logic [9:0] RESULT_RST = 10'h000;
	localparam logic [6:0] SEL_RST    = 7'h00;

	// Selection codes
	localparam logic [6:0] SEL_ADC_GROUND      = 7'h01;
	localparam logic [6:0] SEL_FULLSCALE       = 7'h02;
	localparam logic [6:0] SEL_DC_SENSOR_V     = 7'h03;
	localparam logic [6:0] SEL_DC_SENSOR_I     = 7'h04;
	localparam logic [6:0] SEL_DC_SENSOR_R     = 7'h05;
	localparam logic [6:0] SEL_SQUIB_LOOP      = 7'h06;
	localparam logic [6:0] SEL_BANDGAP_REF     = 7'h07;
	localparam logic [6:0] SEL_BANDGAP_MON     = 7'h08;
	localparam logic [6:0] SEL_TEMPERATURE     = 7'h0a;
	localparam logic [6:0] SEL_DCS_CH0         = 7'h0b;
	localparam logic [6:0] SEL_DCS_CH8         = 7'h13;
	localparam logic [6:0] SEL_ER_ESR_B        = 7'h14;
	localparam logic [6:0] SEL_ER_ESR_C        = 7'h16;
	localparam logic [6:0] SEL_SUPPLY_FIRST    = 7'h21;
	localparam logic [6:0] SEL_INT_SUPPLY      = 7'h22;
	localparam logic [6:0] SEL_SUPPLY_LAST     = 7'h3d;
	localparam logic [6:0] SEL_FEEDBACK_FIRST  = 7'h46;
	localparam logic [6:0] SEL_FEEDBACK_LAST   = 7'h4d;

	// Analog mux source classes
	typedef enum logic [3:0] {
		SRC_UNUSED, SRC_GROUND, SRC_FULLSCALE, SRC_DCS_V, SRC_DCS_I, SRC_DCS_R,
		SRC_SQUIB, SRC_BG_REF, SRC_BG_MON, SRC_TEMP, SRC_DCS_CH, SRC_ER_ESR,
		SRC_SUPPLY_PIN, SRC_FEEDBACK_PIN
	} mux_class_t;

	// One queued request
	typedef struct packed {
		logic [1:0] slot;
		logic [6:0] sel;
	} queue_entry_t;

	// Request presented to the converter
	typedef struct packed {
		mux_class_t class_sel;
		logic [6:0] sel;
		logic [1:0] slot;
	} conv_req_t;

	// Converter completion
	typedef struct packed {
		logic [9:0] value;
		logic [9:0] value_aux;
	} conv_res_t;
endpackage : diag_adc_pkg

// ===== core/diag_adc_request_queue.sv
// Module: four-slot conversion request queue with per-slot result store
`timescale 1ns/100ps

// Overview of operation
// - Four independent request slots; each may select any monitored node.
// - Written frame bits [6:0] carry the selection code; upper bits ignored.
// - Read frame: fresh flag bit 19, selection echo, 10-bit result low bits.
// - A result returns only into the slot that requested it; resistance via A also fills B.
// - Requests during busy conversions are queued, never dropped or aborting.
// - Queued conversions run strictly in arrival order.
// - Queue holds four entries so all slots can be requested back to back.
// - A repeat request for a slot still waiting in the queue overwrites its queued selection.
// - Fresh flag sets on completion, clears when the slot is read.
// - Reading keeps the stored result until a new result replaces it.
// - Pair AB ready is OR of A,B flags; pair CD ready OR of C,D.
// - Codes 01,02,07,08,0A select ground, full scale, references, temperature.
// - Codes 03,04 select sensor voltage, current; 05 resistance returns both.
// - Codes 0B to 13 select DC sensor channels 0 to 8.
// - Codes 14,15,16 select energy reserve ESR samples B, A, C.
// - Code 06 selects the selected squib loop output voltage.
// - Codes 21 to 3D supply and pin voltages; 46 to 4D feedback pins.
// - Sensor resistance only via slot A; current into A, voltage into B.
module diag_adc_request_queue #(
	parameter int unsigned SLOTS = diag_adc_pkg::NUM_SLOTS,
	parameter int unsigned DEPTH = diag_adc_pkg::QUEUE_DEPTH
) (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic                       frame_valid,
	input  wire logic                       frame_write,
	input  wire logic [6:0]                 frame_addr,
	input  wire logic [19:0]                frame_wdata,
	output logic      [19:0]                frame_rdata,
	output logic                            frame_hit,
	output logic                            pair_ab_ready,
	output logic                            pair_cd_ready,
	output logic                            conv_start,
	output diag_adc_pkg::conv_req_t         conv_req,
	input  wire logic                       conv_done,
	input  wire diag_adc_pkg::conv_res_t    conv_res,
	output logic                            conv_busy
);
	import diag_adc_pkg::*;

	// Pointers wrap by overflow, so depth must be a power of two
	if (SLOTS != NUM_SLOTS || DEPTH < SLOTS || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_cfg
		$error("diag_adc_request_queue: unsupported SLOTS or DEPTH");
	end

	localparam int unsigned PTR_W = $clog2(DEPTH);

	typedef enum logic [1:0] {IDLE, LAUNCH, WAIT_DONE} conv_state_t;

	// Map an address to a slot index; valid bit on top
	function automatic logic [2:0] slot_decode(input logic [6:0] addr);
		logic [2:0] r;
		r = 3'b000;
		case (addr)
			MEASURE_SLOT_A_OFS: r = 3'b100;
			MEASURE_SLOT_B_OFS: r = 3'b101;
			MEASURE_SLOT_C_OFS: r = 3'b110;
			MEASURE_SLOT_D_OFS: r = 3'b111;
			default:            r = 3'b000;
		endcase
		return r;
	endfunction : slot_decode

	// Classify a selection code for the analog multiplexer
	function automatic mux_class_t classify(input logic [6:0] sel);
		mux_class_t c;
		c = SRC_UNUSED;
		if (sel == SEL_ADC_GROUND) c = SRC_GROUND;
		else if (sel == SEL_FULLSCALE) c = SRC_FULLSCALE;
		else if (sel == SEL_DC_SENSOR_V) c = SRC_DCS_V;
		else if (sel == SEL_DC_SENSOR_I) c = SRC_DCS_I;
		else if (sel == SEL_DC_SENSOR_R) c = SRC_DCS_R;
		else if (sel == SEL_SQUIB_LOOP) c = SRC_SQUIB;
		else if (sel == SEL_BANDGAP_REF) c = SRC_BG_REF;
		else if (sel == SEL_BANDGAP_MON) c = SRC_BG_MON;
		else if (sel == SEL_TEMPERATURE) c = SRC_TEMP;
		else if (sel >= SEL_DCS_CH0 && sel <= SEL_DCS_CH8) c = SRC_DCS_CH;
		else if (sel >= SEL_ER_ESR_B && sel <= SEL_ER_ESR_C) c = SRC_ER_ESR;
		else if (sel >= SEL_SUPPLY_FIRST && sel <= SEL_SUPPLY_LAST) c = SRC_SUPPLY_PIN;
		else if (sel >= SEL_FEEDBACK_FIRST && sel <= SEL_FEEDBACK_LAST) c = SRC_FEEDBACK_PIN;
		return c;
	endfunction : classify

	logic [2:0]          dec;
	logic                hit;
	logic [1:0]          slot_idx;
	logic                wr_req;
	logic                rd_req;
	logic [6:0]          new_sel;

	logic [6:0]          sel_q     [SLOTS];
	logic [9:0]          result_q  [SLOTS];
	logic [SLOTS-1:0]    fresh_q;
	logic [SLOTS-1:0]    pending_q;

	queue_entry_t        queue_q   [DEPTH];
	logic [PTR_W-1:0]    rd_ptr_q;
	logic [PTR_W-1:0]    wr_ptr_q;
	logic [PTR_W:0]      count_q;
	logic                enq;
	logic                deq;
	logic                merge;
	logic [PTR_W-1:0]    merge_idx;

	conv_state_t         state_q;
	queue_entry_t        active_q;
	logic                done_ok;

	assign dec      = slot_decode(frame_addr);
	assign hit      = dec[2];
	assign slot_idx = dec[1:0];
	assign wr_req   = frame_valid && frame_write && hit;
	assign rd_req   = frame_valid && !frame_write && hit;
	assign new_sel  = frame_wdata[SEL_W-1:0];
	assign frame_hit = frame_valid && hit;

	// Search queue for a pending entry of the written slot
	always_comb begin
		merge_idx = '0;
		merge     = 1'b0;
		for (int i = 0; i < DEPTH; i++) begin
			// Head entry leaving this cycle is already running: no merge
			if (!merge && (PTR_W+1)'(i) < count_q && !(deq && i == 0) &&
			    queue_q[PTR_W'(rd_ptr_q + PTR_W'(i))].slot == slot_idx) begin
				merge     = 1'b1;
				merge_idx = PTR_W'(rd_ptr_q + PTR_W'(i));
			end
		end
	end

	// Overwrite instead of duplicating keeps depth equal to slot count
	assign enq = wr_req && !merge && !(count_q == (PTR_W+1)'(DEPTH) && !deq);
	assign deq = (state_q == IDLE) && (count_q != '0);

	// Queue storage and pointers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_ptr_q <= '0;
			wr_ptr_q <= '0;
			count_q  <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				queue_q[i] <= '0;
			end
		end else begin
			if (wr_req && merge) begin
				queue_q[merge_idx].sel <= new_sel;
			end
			if (enq) begin
				queue_q[wr_ptr_q] <= '{slot: slot_idx, sel: new_sel};
				wr_ptr_q          <= PTR_W'(wr_ptr_q + 1'b1);
			end
			if (deq) begin
				rd_ptr_q <= PTR_W'(rd_ptr_q + 1'b1);
			end
			count_q <= (PTR_W+1)'(count_q + (PTR_W+1)'(enq) - (PTR_W+1)'(deq));
		end
	end

	// Conversion sequencer; running conversion is never aborted
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q  <= IDLE;
			active_q <= '0;
		end else begin
			case (state_q)
				IDLE: begin
					if (deq) begin
						active_q <= queue_q[rd_ptr_q];
						state_q  <= LAUNCH;
					end
				end
				LAUNCH: begin
					state_q <= WAIT_DONE;
				end
				WAIT_DONE: begin
					if (conv_done) begin
						state_q <= IDLE;
					end
				end
				default: begin
					state_q <= IDLE;
				end
			endcase
		end
	end

	assign done_ok = (state_q == WAIT_DONE) && conv_done;

	// Per-slot state: selection echo, pending, result, fresh flag
	for (genvar s = 0; s < SLOTS; s++) begin : g_slot
		logic res_hit;
		logic aux_hit;
		// Resistance fills A with current and B with voltage
		assign res_hit = done_ok && active_q.slot == 2'(s);
		assign aux_hit = done_ok && s == 1 && active_q.slot == 2'd0 &&
		                 active_q.sel == SEL_DC_SENSOR_R;

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				sel_q[s]     <= SEL_RST;
				pending_q[s] <= 1'b0;
			end else begin
				if (wr_req && slot_idx == 2'(s)) begin
					sel_q[s] <= new_sel;
				end
				if (wr_req && slot_idx == 2'(s)) begin
					pending_q[s] <= 1'b1;
				end else if (res_hit) begin
					pending_q[s] <= 1'b0;
				end
			end
		end

		// Result survives reads until the next conversion lands
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				result_q[s] <= RESULT_RST;
			end else if (res_hit) begin
				result_q[s] <= conv_res.value;
			end else if (aux_hit) begin
				result_q[s] <= conv_res.value_aux;
			end
		end

		// Completion sets flag and wins over a read in the same cycle
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				fresh_q[s] <= 1'b0;
			end else if (res_hit || aux_hit) begin
				fresh_q[s] <= 1'b1;
			end else if (rd_req && slot_idx == 2'(s)) begin
				fresh_q[s] <= 1'b0;
			end
		end
	end

	// Read frame captured in a flop, valid the cycle after the read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frame_rdata <= '0;
		end else if (rd_req) begin
			frame_rdata <= '0;
			frame_rdata[FRESH_BIT] <= fresh_q[slot_idx];
			frame_rdata[SEL_ECHO_LO +: SEL_W] <= sel_q[slot_idx];
			frame_rdata[RESULT_LO +: RES_W] <= result_q[slot_idx];
		end
	end

	// Global status pair bits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pair_ab_ready <= 1'b0;
			pair_cd_ready <= 1'b0;
		end else begin
			pair_ab_ready <= fresh_q[0] | fresh_q[1];
			pair_cd_ready <= fresh_q[2] | fresh_q[3];
		end
	end

	// Converter request: class decoded here, analog side reacts to it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			conv_req <= '0;
		end else if (deq) begin
			conv_req.sel       <= queue_q[rd_ptr_q].sel;
			conv_req.slot      <= queue_q[rd_ptr_q].slot;
			conv_req.class_sel <= classify(queue_q[rd_ptr_q].sel);
		end
	end

	assign conv_start = (state_q == LAUNCH);
	assign conv_busy  = (state_q != IDLE);

endmodule : diag_adc_request_queue

// ===== verif/queue_monitor.sv
// Checker: port-level properties of the conversion request queue
`timescale 1ns/100ps
module queue_monitor
	import diag_adc_pkg::*;
(
	input wire logic                    clk,
	input wire logic                    sys_rst,
	input wire logic                    frame_valid,
	input wire logic                    frame_write,
	input wire logic [6:0]              frame_addr,
	input wire logic [19:0]             frame_rdata,
	input wire logic                    frame_hit,
	input wire logic                    pair_ab_ready,
	input wire logic                    pair_cd_ready,
	input wire logic                    conv_start,
	input wire diag_adc_pkg::conv_req_t conv_req,
	input wire logic                    conv_done,
	input wire logic                    conv_busy
);
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_HIT: assert property (frame_hit == (frame_valid && frame_addr >= MEASURE_SLOT_A_OFS
		&& frame_addr <= MEASURE_SLOT_D_OFS)) else $error("slot decode wrong");
	AST_RST: assert property (disable iff (1'b0) sys_rst |=> frame_rdata == 20'h0_0000
		&& !pair_ab_ready && !pair_cd_ready && !conv_busy) else $error("reset state wrong");
	AST_PAD: assert property (frame_rdata[11:10] == 2'h0) else $error("read pad bits set");
	AST_HOLD: assert property (!(frame_valid && !frame_write) [*2] |=> $stable(frame_rdata))
		else $error("read word changed without a read");
	AST_LAUNCH: assert property (frame_valid && frame_write && frame_hit && !conv_busy
		&& !conv_start |-> ##[1:3] conv_start) else $error("idle request not launched");
	AST_STEADY: assert property (!conv_start |-> $stable(conv_req))
		else $error("request changed mid conversion");
	AST_BUSY: assert property (conv_busy && !conv_done |=> conv_busy)
		else $error("conversion aborted");
	AST_AB: assert property (conv_busy && conv_done && conv_req.slot < 2'h2
		|-> ##[1:3] pair_ab_ready) else $error("pair ab not raised");
	AST_CD: assert property (conv_busy && conv_done && conv_req.slot >= 2'h2
		|-> ##[1:3] pair_cd_ready) else $error("pair cd not raised");
	// Main scenarios reached
	cover property (conv_start);
	cover property (frame_valid && !frame_write && frame_hit);
	cover property (pair_ab_ready && pair_cd_ready);
endmodule : queue_monitor

bind diag_adc_request_queue queue_monitor mon (.clk, .sys_rst, .frame_valid, .frame_write,
	.frame_addr, .frame_rdata, .frame_hit, .pair_ab_ready, .pair_cd_ready, .conv_start,
	.conv_req, .conv_done, .conv_busy);

// ===== verif/converter_model.sv
// Converter stand-in: answers each launch after a chosen latency
`timescale 1ns/100ps
module converter_model
	import diag_adc_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire logic                    conv_start,
	input  wire diag_adc_pkg::conv_req_t conv_req,
	input  wire logic [3:0]              lat,
	output logic                         conv_done,
	output diag_adc_pkg::conv_res_t      conv_res
);
	logic [3:0] cnt_q;
	logic       run_q;
	// Value encodes code and slot so a misrouted result shows
	always_ff @(posedge clk) begin
		conv_done <= 1'b0;
		conv_res <= ~conv_res; // Not held outside the pulse
		if (sys_rst) begin
			run_q <= 1'b0;
			conv_res <= '0;
		end else if (conv_start) begin
			run_q <= 1'b1;
			cnt_q <= lat;
		end else if (run_q && cnt_q == 4'h0) begin
			run_q <= 1'b0;
			conv_done <= 1'b1;
			conv_res <= {1'b1, conv_req.sel, conv_req.slot, ~{1'b1, conv_req.sel, conv_req.slot}};
		end else if (run_q) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule : converter_model

// ===== verif/diag_adc_request_queue_tb.sv
// Testbench: slot requests, queue order and result read-back
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_errors++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module diag_adc_request_queue_tb;
	import diag_adc_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        frame_valid = 1'b0;
	logic        frame_write = 1'b0;
	logic [6:0]  frame_addr = 7'h00;
	logic [19:0] frame_wdata = 20'h0_0000;
	logic [19:0] frame_rdata;
	logic        frame_hit, pair_ab_ready, pair_cd_ready, conv_start, conv_done, conv_busy;
	conv_req_t   conv_req;
	conv_res_t   conv_res;
	logic [3:0]  lat = 4'h8;
	logic [1:0]  order[$];
	logic [6:0]  codes[20] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h07, 7'h08, 7'h09,
		7'h0a, 7'h0b, 7'h13, 7'h14, 7'h15, 7'h16, 7'h21, 7'h22, 7'h3d, 7'h46, 7'h4d};
	logic [6:0]  sel[4] = '{7'h0b, 7'h01, 7'h16, 7'h22};
	int          n_errors = 0;
	int          n_compared = 0;
	int          n_starts = 0;

	diag_adc_request_queue DUT (.clk, .sys_rst, .frame_valid, .frame_write, .frame_addr,
		.frame_wdata, .frame_rdata, .frame_hit, .pair_ab_ready, .pair_cd_ready, .conv_start,
		.conv_req, .conv_done, .conv_res, .conv_busy);
	converter_model conv (.clk, .sys_rst, .conv_start, .conv_req, .lat, .conv_done, .conv_res);

	// 25 MHz clock
	always #20 clk = ~clk;

	// Launch log, sampled mid-cycle where the launch pulse is settled
	always @(negedge clk) begin
		if (conv_start === 1'b1) begin
			order.push_back(conv_req.slot);
			n_starts++;
		end
	end

	function automatic logic [19:0] word(input logic f, input logic [6:0] c, input logic [1:0] s);
		return {f, c, 2'b00, 1'b1, c, s};
	endfunction : word

	task automatic put(input logic [6:0] a, input logic w, input logic [19:0] d);
		@(posedge clk);
		frame_valid <= 1'b1;
		frame_write <= w;
		frame_addr <= a;
		frame_wdata <= d;
		@(posedge clk);
		frame_valid <= 1'b0;
	endtask : put

	task automatic rd(input logic [1:0] s);
		put(MEASURE_SLOT_A_OFS + 7'(s), 1'b0, 20'h0_0000);
		@(posedge clk);
		#1;
	endtask : rd

	// Bounded wait for a launch count and an idle converter
	task automatic settle(input int want);
		int k;
		k = 0;
		while ((n_starts != want || conv_busy !== 1'b0) && k < 300) begin
			@(posedge clk);
			k++;
		end
		repeat (4) @(posedge clk);
	endtask : settle

	task automatic end_of_test;
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// Hang guard, far beyond the expected run
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		end_of_test();
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		for (int s = 0; s < 4; s++) begin
			rd(s[1:0]);
			`CHK("reset word", 20'h0_0000, frame_rdata)
		end
		// Four back-to-back requests with junk upper bits, then a repeat on D
		for (int s = 0; s < 4; s++)
			put(MEASURE_SLOT_A_OFS + 7'(s), 1'b1, {13'h1fff, s == 3 ? 7'h4d : sel[s]});
		put(MEASURE_SLOT_D_OFS, 1'b1, 20'h0_0022);
		settle(4);
		`CHK("launches", 4, n_starts)
		for (int s = 0; s < 4; s++)
			`CHK("order", s[1:0], order[s])
		`CHK("pair ab", 1'b1, pair_ab_ready)
		`CHK("pair cd", 1'b1, pair_cd_ready)
		for (int s = 0; s < 4; s++) begin
			rd(s[1:0]);
			`CHK("fresh word", word(1'b1, sel[s], s[1:0]), frame_rdata)
			@(posedge clk);
			if (s == 1)
				`CHK("pair ab after read", 1'b0, pair_ab_ready)
		end
		for (int s = 0; s < 4; s++) begin
			rd(s[1:0]);
			`CHK("reread word", word(1'b0, sel[s], s[1:0]), frame_rdata)
		end
		// Every listed code, prompt converter
		lat <= 4'h0;
		for (int i = 0; i < 20; i++) begin
			put(MEASURE_SLOT_A_OFS + 7'(i % 4), 1'b1, {13'h0000, codes[i]});
			settle(5 + i);
			rd(2'(i % 4));
			`CHK("code word", word(1'b1, codes[i], 2'(i % 4)), frame_rdata)
		end
		// Resistance via A fills A and B
		put(MEASURE_SLOT_A_OFS, 1'b1, 20'h0_0005);
		settle(25);
		rd(2'h0);
		`CHK("resistance A", word(1'b1, 7'h05, 2'h0), frame_rdata)
		rd(2'h1);
		`CHK("resistance B", {1'b1, ~{1'b1, 7'h05, 2'h0}}, {frame_rdata[19], frame_rdata[9:0]})
		// Unmapped address launches nothing
		put(7'h3e, 1'b1, 20'h0_0001);
		repeat (6) @(posedge clk);
		`CHK("unmapped", 25, n_starts)
		// Reset in mid conversion
		lat <= 4'hf;
		put(MEASURE_SLOT_A_OFS, 1'b1, 20'h0_000b);
		repeat (4) @(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(2'h0);
		`CHK("word after reset", 20'h0_0000, frame_rdata)
		end_of_test();
	end
endmodule : diag_adc_request_queue_tb
